/* rtl/mts_limit_counter.sv */
// Top of the multiturn limit counter: AHB-Lite registers, power-up check, alarm.
`timescale 1ns/1ps
module mts_limit_counter (
  // Clock and reset.
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  // AHB-Lite slave.
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  // Encoder side pins.
  input  wire logic                         encFwdTurn,
  input  wire logic                         encRevTurn,
  input  wire logic [mts_pkg::LIMIT_W-1:0]  encStoredLimit,
  output logic      [mts_pkg::LIMIT_W-1:0]  encLimitWrData,
  output logic                              encLimitWrStb,
  // Alarm code outputs, active low.
  output logic                              alarmCodeOutA_n,
  output logic                              alarmCodeOutB_n,
  output logic                              alarmCodeOutC_n,
  // Interrupt.
  output logic                              irq
);
  import mts_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // All state lives in one record.
  typedef struct packed {
    mts_state_t         state;         // Power-up sequence state.
    logic [3:0]         settle;        // Settle counter before the compare.
    logic               usagePend;     // Usage written by software.
    logic [LIMIT_W-1:0] limitPend;     // Limit written by software.
    logic               usageAct;      // Usage in force.
    logic [LIMIT_W-1:0] limitAct;      // Limit in force.
    logic               alarm;         // Mismatch alarm active.
    logic               restartNeeded; // Encoder written, power cycle due.
    logic [IRQ_W-1:0]   irqStat;       // Sticky events.
    logic [IRQ_W-1:0]   irqMask;       // Event enables.
    logic               wrPend;        // Write data phase pending.
    logic [7:0]         wrAddr;        // Address of the pending write.
    logic [31:0]        rdata;         // Read data for the data phase.
    logic               encWrStb;      // Encoder limit write pulse.
    logic [LIMIT_W-1:0] encWrData;     // Limit sent to the encoder.
    logic               almA_n;        // Alarm code output A.
    logic               almB_n;        // Alarm code output B.
    logic               almC_n;        // Alarm code output C.
    logic               irq;           // Interrupt level.
    logic               fwdPrev;       // Previous synchronised forward level.
    logic               revPrev;       // Previous synchronised reverse level.
  } mts_top_state_t;

  mts_top_state_t     st_q;            // Registered state.
  mts_top_state_t     st_d;            // Next state.

  // ----------------------------------------------------------------
  // Synchronisers and counter
  // ----------------------------------------------------------------
  // Pin copies and counter results.
  logic [LIMIT_W+1:0] pinSync;         // Synchronised encoder pins.
  logic               fwdLvl;          // Forward revolution level.
  logic               revLvl;          // Reverse revolution level.
  logic [LIMIT_W-1:0] encLimit;        // Limit held in the encoder.
  logic [LIMIT_W-1:0] turnCount;       // Multiturn count.
  logic               turnWrapped;     // Wrap pulse from the counter.
  logic               cntClear;        // Counter cleared during power-up.
  logic               cntEnable;       // Tracking allowed.
  logic               fwdPulse;        // Rising edge of forward level.
  logic               revPulse;        // Rising edge of reverse level.

  // Pins cross in through two flops.
  mts_sync #(
    .WIDTH (LIMIT_W + 2)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  ({encFwdTurn, encRevTurn, encStoredLimit}),
    .syncOut  (pinSync)
  );

  assign fwdLvl    = pinSync[LIMIT_W+1];
  assign revLvl    = pinSync[LIMIT_W];
  assign encLimit  = pinSync[LIMIT_W-1:0];
  // Rising pin edges count turns.
  assign fwdPulse  = fwdLvl && !st_q.fwdPrev;
  assign revPulse  = revLvl && !st_q.revPrev;
  assign cntClear  = (st_q.state == ST_BOOT);
  // Incremental use keeps no multiturn count at all.
  assign cntEnable = (st_q.state == ST_RUN) && (st_q.usageAct == USAGE_ABS);

  // Counts only in the run state.
  // Limits change only at power-up.
  mts_turn_counter #(
    .W (LIMIT_W)
  ) u_counter (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (cntClear),
    .enable   (cntEnable),
    .limit    (st_q.limitAct),
    .fwdTurn  (fwdPulse),
    .revTurn  (revPulse),
    .count    (turnCount),
    .wrapped  (turnWrapped)
  );

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // The count is sign extended only in the signed full-range mode.
  // Shared by every register read.
  function automatic logic [31:0] readReg(input logic [7:0] addr, input mts_top_state_t s,
                                          input logic [LIMIT_W-1:0] cnt,
                                          input logic [LIMIT_W-1:0] encLim);
    logic [31:0] v;
    v = 32'h0000_0000;
    // Unmapped offsets read zero.
    case (addr)
      ADDR_USAGE:     v[0] = s.usagePend;
      ADDR_LIMIT:     v[LIMIT_W-1:0] = s.limitPend;
      ADDR_ACTIVE:    v = {15'h0000, s.usageAct, s.limitAct};
      ADDR_COUNT:     v = (s.limitAct == LIMIT_MAX) ? {{16{cnt[LIMIT_W-1]}}, cnt}
                                                    : {16'h0000, cnt};
      ADDR_ALARM:     v = {30'h0000_0000, s.restartNeeded, s.alarm};
      ADDR_IRQ_STAT:  v[IRQ_W-1:0] = s.irqStat;
      ADDR_IRQ_MASK:  v[IRQ_W-1:0] = s.irqMask;
      ADDR_ENC_LIMIT: v[LIMIT_W-1:0] = encLim;
      default:        v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Strobes for this cycle only.
  logic             addrPhase;         // Valid address phase this cycle.
  logic [IRQ_W-1:0] irqSet;            // Events raised this cycle.
  logic [IRQ_W-1:0] irqClr;            // Bits cleared by a status read.
  logic             restartReq;        // Software power-up request.
  logic             wrFuncReq;         // Encoder limit write request.

  // One process builds all next state.
  always_comb begin
    st_d        = st_q;
    irqSet      = '0;
    irqClr      = '0;
    restartReq  = 1'b0;
    wrFuncReq   = 1'b0;
    addrPhase   = hsel && hready && (htrans == HTRANS_NONSEQ);
    st_d.fwdPrev  = fwdLvl;
    st_d.revPrev  = revLvl;
    st_d.encWrStb = 1'b0;

    // Address phase: reads are answered in the next cycle with zero wait.
    // Status reads clear what they show.
    if (addrPhase) begin
      st_d.wrPend = hwrite;
      st_d.wrAddr = haddr[7:0];
      st_d.rdata  = hwrite ? 32'h0000_0000 : readReg(haddr[7:0], st_q, turnCount, encLimit);
      if (!hwrite && (haddr[7:0] == ADDR_IRQ_STAT)) begin
        irqClr = st_q.irqStat;
      end
    end else if (hready) begin
      st_d.wrPend = 1'b0;
    end

    // Data phase of a write: the pending settings and the event mask change here; ADDR_CMD and ADDR_RESTART raise one-cycle requests.
    // Other offsets hold rdata, so a read whose address phase falls in the same cycle gets the old data.
    if (st_q.wrPend) begin
      case (st_q.wrAddr)
        ADDR_USAGE:    st_d.usagePend = hwdata[0];
        ADDR_LIMIT:    st_d.limitPend = hwdata[LIMIT_W-1:0];
        ADDR_IRQ_MASK: st_d.irqMask   = hwdata[IRQ_W-1:0];
        ADDR_CMD:      wrFuncReq      = hwdata[0];
        ADDR_RESTART:  restartReq     = hwdata[0];
        default:       st_d.rdata     = st_q.rdata;
      endcase
    end

    // Boot, check, then run.
    // Power-up sequence.
    case (st_q.state)
      ST_BOOT: begin
        // The count stays clear here.
        // Let the encoder limit pass the synchroniser before comparing it.
        st_d.settle = 4'(st_q.settle + 1'b1);
        if (st_q.settle >= SETTLE_CYCLES) begin
          st_d.state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // The alarm holds until the limit is written or a software power-up is requested.
        st_d.state = ST_RUN;
        if ((st_q.usageAct == USAGE_ABS) && (encLimit != st_q.limitAct)) begin
          st_d.alarm = 1'b1;
          irqSet[IRQ_MISMATCH] = 1'b1;
        end
      end
      ST_RUN: begin
        // Encoder writes only run here.
        if (wrFuncReq) begin
          if (st_q.alarm) begin
            // The limit goes out as it stands; a bad value is not caught here.
            st_d.encWrData     = st_q.limitAct;
            st_d.encWrStb      = 1'b1;
            st_d.alarm         = 1'b0;
            st_d.restartNeeded = 1'b1;
            irqSet[IRQ_WR_DONE] = 1'b1;
          end else begin
            irqSet[IRQ_WR_REFUSED] = 1'b1;
          end
        end
        // Wrap events are kept too.
        irqSet[IRQ_WRAP] = turnWrapped;
      end
      default: begin
        // A bad state reboots.
        st_d.state = ST_BOOT;
      end
    endcase

    // A software power-up takes the pending settings into force.
    // The limit compare runs again.
    if (restartReq) begin
      st_d.state         = ST_BOOT;
      st_d.settle        = 4'h0;
      st_d.usageAct      = st_q.usagePend;
      st_d.limitAct      = st_q.limitPend;
      st_d.alarm         = 1'b0;
      st_d.restartNeeded = 1'b0;
    end

    // Set wins over the read clear so no event is lost.
    st_d.irqStat = (st_q.irqStat & ~irqClr) | irqSet;
    // The mask lags its write by a cycle.
    st_d.irq     = |(st_d.irqStat & st_q.irqMask);

    // Mismatch shows low-high-low; no alarm leaves all three high.
    // Outputs track the next alarm.
    st_d.almA_n = !st_d.alarm;
    st_d.almB_n = 1'b1;
    st_d.almC_n = !st_d.alarm;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset stands for power-up with factory settings.
  // Unnamed fields reset to zero.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q               <= '0;
      st_q.state         <= ST_BOOT;
      st_q.usagePend     <= USAGE_RESET;
      st_q.limitPend     <= LIMIT_RESET;
      st_q.usageAct      <= USAGE_RESET;
      st_q.limitAct      <= LIMIT_RESET;
      st_q.irqMask       <= IRQ_MASK_RESET;
      st_q.almA_n        <= 1'b1;
      st_q.almB_n        <= 1'b1;
      st_q.almC_n        <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output except hreadyout and hresp is a field of the state register.
  // The bus never stalls or errors.
  assign hrdata          = st_q.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign encLimitWrData  = st_q.encWrData;
  assign encLimitWrStb   = st_q.encWrStb;
  assign alarmCodeOutA_n = st_q.almA_n;
  assign alarmCodeOutB_n = st_q.almB_n;
  assign alarmCodeOutC_n = st_q.almC_n;
  assign irq             = st_q.irq;
endmodule

/* rtl/mts_pkg.sv */
// Shared constants, register map and state encoding for the multiturn limit counter.
package mts_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int          LIMIT_W         = 16;          // Turn count and limit width.
  localparam int          CLK_PERIOD_NS   = 10;          // Core clock period in ns.
  localparam int          SETTLE_NS       = 40;          // Wait before limit compare, ns.
  localparam logic [3:0]  SETTLE_CYCLES   = 4'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] LIMIT_MAX       = 16'hFFFF;    // Maximum limit, signed count mode.
  localparam logic [15:0] LIMIT_RESET     = 16'hFFFF;    // Factory turn wrap limit.
  localparam logic        USAGE_ABS       = 1'b0;        // Absolute with multiturn tracking.
  localparam logic        USAGE_INC       = 1'b1;        // Incremental only.
  localparam logic        USAGE_RESET     = 1'b0;        // Factory usage setting.

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_USAGE      = 8'h00;       // Pending encoder usage select.
  localparam logic [7:0]  ADDR_LIMIT      = 8'h04;       // Pending turn wrap limit.
  localparam logic [7:0]  ADDR_ACTIVE     = 8'h08;       // Settings in force since power-up.
  localparam logic [7:0]  ADDR_CMD        = 8'h0C;       // Encoder limit write command.
  localparam logic [7:0]  ADDR_COUNT      = 8'h10;       // Multiturn count.
  localparam logic [7:0]  ADDR_ALARM      = 8'h14;       // Alarm and status flags.
  localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h18;       // Sticky events, cleared by read.
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h1C;       // Event enables.
  localparam logic [7:0]  ADDR_ENC_LIMIT  = 8'h20;       // Limit reported by the encoder.
  localparam logic [7:0]  ADDR_RESTART    = 8'h24;       // Write 1 to emulate a power-up.

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          ACT_USAGE_BIT   = 16;          // Active usage bit in ACTIVE.
  localparam int          ALM_MISMATCH    = 0;           // Mismatch alarm active.
  localparam int          ALM_RESTART     = 1;           // Power cycle needed.
  localparam int          IRQ_W           = 4;           // Number of event bits.
  localparam int          IRQ_MISMATCH    = 0;           // Mismatch alarm raised.
  localparam int          IRQ_WR_DONE     = 1;           // Encoder limit written.
  localparam int          IRQ_WR_REFUSED  = 2;           // Encoder limit write refused.
  localparam int          IRQ_WRAP        = 3;           // Count wrapped.
  localparam logic [3:0]  IRQ_MASK_RESET  = 4'h0;        // All events masked after reset.

  // ----------------------------------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'b10;       // Single transfer.

  // ----------------------------------------------------------------
  // Power-up sequence states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_BOOT  = 2'b00,
    ST_CHECK = 2'b01,
    ST_RUN   = 2'b10
  } mts_state_t;

endpackage

/* rtl/mts_sync.sv */
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module mts_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Asynchronous input and its synchronised copy.
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  import mts_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] meta;   // First stage, read only by the second.
    logic [WIDTH-1:0] stable; // Second stage.
  } mts_sync_state_t;

  mts_sync_state_t st_q;      // Registered state.
  mts_sync_state_t st_d;      // Next state.

  // The first stage feeds only the second, so metastability never spreads.
  always_comb begin
    st_d        = st_q;
    st_d.meta   = asyncIn;
    st_d.stable = st_q.meta;
  end

  // Register the state; reset clears both stages.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign syncOut = st_q.stable;
endmodule

/* rtl/mts_turn_counter.sv */
// Multiturn revolution counter with configurable wrap limit.
`timescale 1ns/1ps
module mts_turn_counter #(
  parameter int W = mts_pkg::LIMIT_W
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Control.
  input  wire logic         clear,
  input  wire logic         enable,
  input  wire logic [W-1:0] limit,
  // Revolution pulses, one cycle each.
  input  wire logic         fwdTurn,
  input  wire logic         revTurn,
  // Results.
  output logic      [W-1:0] count,
  output logic              wrapped
);
  import mts_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] count;   // Current multiturn count.
    logic         wrapped; // Pulse when the count wrapped.
  } mts_cnt_state_t;

  mts_cnt_state_t st_q;    // Registered state.
  mts_cnt_state_t st_d;    // Next state.
  logic           maxMode; // Limit at maximum: free signed wrap.

  // Both pulses in one cycle cancel out, which also keeps the count exact.
  always_comb begin
    st_d         = st_q;
    st_d.wrapped = 1'b0;
    maxMode      = (limit == LIMIT_MAX);
    if (clear) begin
      st_d.count = '0;
    end else if (enable && fwdTurn && !revTurn) begin
      if (maxMode) begin
        st_d.count   = W'(st_q.count + 1'b1);
        st_d.wrapped = (st_q.count == {1'b0, {(W-1){1'b1}}});
      end else if (st_q.count == limit) begin
        st_d.count   = '0;
        st_d.wrapped = 1'b1;
      end else begin
        st_d.count   = W'(st_q.count + 1'b1);
      end
    end else if (enable && revTurn && !fwdTurn) begin
      if (maxMode) begin
        st_d.count   = W'(st_q.count - 1'b1);
        st_d.wrapped = (st_q.count == {1'b1, {(W-1){1'b0}}});
      end else if (st_q.count == '0) begin
        st_d.count   = limit;
        st_d.wrapped = 1'b1;
      end else begin
        st_d.count   = W'(st_q.count - 1'b1);
      end
    end
  end

  // Register the state.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count   = st_q.count;
  assign wrapped = st_q.wrapped;
endmodule

/* test/mts_enc_model.sv */
// Behavioural absolute encoder: revolution pins and a stored turn wrap limit.
`timescale 1ns/1ps
module mts_enc_model (
  // Clock.
  input  wire logic        core_clk,
  // Limit write from the drive.
  input  wire logic [15:0] wrData,
  input  wire logic        wrStb,
  // Revolution pins and the stored limit.
  output logic             fwdTurn,
  output logic             revTurn,
  output logic      [15:0] storedLimit
);
  // The stored limit is non-volatile, so it ignores the drive's reset.
  initial begin
    fwdTurn = 1'b0;
    revTurn = 1'b0;
    storedLimit = 16'hFFFF;
  end
  // Accept the drive's limit with no sanity check.
  always @(posedge core_clk) begin
    if (wrStb) begin
      storedLimit <= wrData;
    end
  end
  // One full revolution; pulses are wide so the drive's synchroniser sees them.
  task automatic turn(input logic fwd);
    @(posedge core_clk);
    if (fwd) fwdTurn <= 1'b1;
    else revTurn <= 1'b1;
    repeat (4) @(posedge core_clk);
    fwdTurn <= 1'b0;
    revTurn <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  // Preload a different stored limit between runs.
  task automatic preset(input logic [15:0] v);
    storedLimit <= v;
  endtask
endmodule

/* test/mts_limit_counter_props.sv */
// Concurrent checks on the ports of the multiturn limit counter.
`timescale 1ns/1ps
module mts_limit_counter_props (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        rst,
  // Bus response.
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Encoder side.
  input wire logic [15:0] encStoredLimit,
  input wire logic [15:0] encLimitWrData,
  input wire logic        encLimitWrStb,
  // Alarm code, active low.
  input wire logic        alarmCodeOutA_n,
  input wire logic        alarmCodeOutB_n,
  input wire logic        alarmCodeOutC_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  // Start of an encoder limit write.
  sequence s_pulse;
    $rose(encLimitWrStb);
  endsequence
  // Power-up with the encoder holding the factory limit.
  sequence s_boot_match;
    $fell(rst) ##0 (encStoredLimit == 16'hFFFF)[*8];
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_code_shape: assert property (alarmCodeOutB_n && (alarmCodeOutA_n == alarmCodeOutC_n))
    else $error("alarm code outside its two legal patterns");
  a_strobe_single: assert property (s_pulse |=> !encLimitWrStb)
    else $error("limit write strobe longer than one cycle");
  a_strobe_clears: assert property (encLimitWrStb |-> alarmCodeOutA_n && alarmCodeOutC_n)
    else $error("alarm still shown while limit is written");
  a_strobe_gated: assert property (s_pulse |-> $past(!alarmCodeOutA_n))
    else $error("limit written without an active mismatch alarm");
  a_wrdata_holds: assert property (encLimitWrStb |=> $stable(encLimitWrData)[*4])
    else $error("limit write data changed after strobe");
  a_match_quiet: assert property (s_boot_match |=> alarmCodeOutA_n[*4])
    else $error("mismatch alarm with matching limits");
  a_boot_settle: assert property ($fell(rst) |-> alarmCodeOutA_n[*5])
    else $error("alarm raised before the limit compare");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answered with wait or error");
endmodule

bind mts_limit_counter mts_limit_counter_props uChk (.core_clk(core_clk), .rst(rst),
  .hreadyout(hreadyout), .hresp(hresp), .encStoredLimit(encStoredLimit),
  .encLimitWrData(encLimitWrData), .encLimitWrStb(encLimitWrStb),
  .alarmCodeOutA_n(alarmCodeOutA_n), .alarmCodeOutB_n(alarmCodeOutB_n),
  .alarmCodeOutC_n(alarmCodeOutC_n));

/* test/multiturn_limit_counter_tb_top.sv */
// Self-checking testbench for the multiturn limit counter.
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module multiturn_limit_counter_tb_top;
  import mts_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        core_clk, rst, hsel, hwrite, hreadyout, hresp, irq, wrStb, fwd, rev;
  logic        almA_n, almB_n, almC_n;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] encLim, wrData;
  int          n_fail = 0;
  int          samples_checked = 0;
  // Clock at 100 MHz.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  mts_limit_counter uut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .encFwdTurn(fwd),
    .encRevTurn(rev), .encStoredLimit(encLim), .encLimitWrData(wrData),
    .encLimitWrStb(wrStb), .alarmCodeOutA_n(almA_n), .alarmCodeOutB_n(almB_n),
    .alarmCodeOutC_n(almC_n), .irq(irq));
  mts_enc_model enc (.core_clk(core_clk), .wrData(wrData), .wrStb(wrStb), .fwdTurn(fwd),
    .revTurn(rev), .storedLimit(encLim));
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  // One single AHB-Lite word transfer; waits for hready in both phases.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= 32'(a);
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsize <= 3'b010;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0000_0000, q);
    `CHK(q, exp)
  endtask
  // Emulated power cycle, then time for the limit compare.
  task automatic restart();
    wr(ADDR_RESTART, 32'h0000_0001);
    repeat (15) @(posedge core_clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_boot();
    chk_rd(ADDR_LIMIT, 32'h0000_FFFF);
    chk_rd(ADDR_ACTIVE, 32'h0000_FFFF);
    chk_rd(8'h3C, 32'h0000_0000);
    `CHK({almA_n, almB_n, almC_n}, 3'b111)
    $display("boot test done");
  endtask
  // Default limit: the count is signed and steps once per turn.
  task automatic t_signed();
    enc.turn(1'b1);
    chk_rd(ADDR_COUNT, 32'h0000_0001);
    enc.turn(1'b0);
    enc.turn(1'b0);
    chk_rd(ADDR_COUNT, 32'hFFFF_FFFF);
    $display("signed count test done");
  endtask
  // Three-turn machine: mismatch alarm, masked interrupt, wrap both ways.
  task automatic t_wrap();
    wr(ADDR_LIMIT, 32'h0000_0002);
    chk_rd(ADDR_ACTIVE, 32'h0000_FFFF);
    restart();
    `CHK({almA_n, almB_n, almC_n}, 3'b010)
    chk_rd(ADDR_ALARM, 32'h0000_0001);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_MASK, 32'h0000_000F);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 1'b1)
    chk_rd(ADDR_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 1'b0)
    enc.turn(1'b0);
    chk_rd(ADDR_COUNT, 32'h0000_0002);
    enc.turn(1'b1);
    enc.turn(1'b1);
    chk_rd(ADDR_COUNT, 32'h0000_0001);
    $display("wrap test done");
  endtask
  // Limit write accepted while the alarm stands, refused once it is gone.
  task automatic t_write();
    wr(ADDR_CMD, 32'h0000_0001);
    repeat (3) @(posedge core_clk);
    `CHK(encLim, 16'h0002)
    `CHK({almA_n, almB_n, almC_n}, 3'b111)
    chk_rd(ADDR_ALARM, 32'h0000_0002);
    chk_rd(ADDR_ENC_LIMIT, 32'h0000_0002);
    chk_rd(ADDR_IRQ_STAT, 32'h0000_000A);
    wr(ADDR_CMD, 32'h0000_0001);
    repeat (3) @(posedge core_clk);
    chk_rd(ADDR_IRQ_STAT, 32'h0000_0004);
    restart();
    `CHK({almA_n, almB_n, almC_n}, 3'b111)
    chk_rd(ADDR_ACTIVE, 32'h0000_0002);
    $display("limit write test done");
  endtask
  // Incremental use: no compare and no counting.
  task automatic t_incr();
    enc.preset(16'h0005);
    wr(ADDR_USAGE, 32'h0000_0001);
    restart();
    chk_rd(ADDR_ACTIVE, 32'h0001_0002);
    `CHK({almA_n, almB_n, almC_n}, 3'b111)
    enc.turn(1'b1);
    chk_rd(ADDR_COUNT, 32'h0000_0000);
    $display("incremental test done");
  endtask
  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // The whole run needs under 2000 cycles; a hang stops far beyond that.
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (12) @(posedge core_clk);
    t_boot();
    t_signed();
    t_wrap();
    t_write();
    t_incr();
    tally_and_finish();
  end
endmodule
